/* File: logic/rtc_pkg.sv */
package rtc_pkg;
	// ----------------------------------------
	// message codes and subcodes
	// ----------------------------------------
	localparam logic [7:0] CMD_RATE = 8'h21;
	localparam logic [7:0] CMD_EVT = 8'h2A;
	localparam logic [7:0] CMD_TIME = 8'h2B;
	localparam logic [7:0] CMD_DIST = 8'h2C;
	localparam logic [7:0] CMD_HDG = 8'h2D;
	localparam logic [7:0] CMD_SEVT = 8'h2E;
	localparam logic [7:0] CMD_TEST = 8'h2F;
	localparam logic [7:0] SUB_ONE = 8'h01;
	localparam logic [7:0] SUB_ALL = 8'hFF;
	localparam logic [7:0] SUB_COLL = 8'h02;
	localparam logic [7:0] SUB_GYRO = 8'h04;
	localparam logic [7:0] SUB_TACHO = 8'h06;
	localparam logic [7:0] RPT_TEST = 8'h3F;
	localparam logic [7:0] RATE_5HZ = 8'h05;
	localparam logic [7:0] RATE_10HZ = 8'h0A;
	localparam logic RATE_RST_10HZ = 1'b1;
	localparam logic [1:0] ACK_OK = 2'h0;
	localparam logic [1:0] ACK_CONTRA = 2'h1;
	localparam logic [1:0] ACK_ERR = 2'h2;
	localparam logic [15:0] MAX_COLL_S = 16'h0E10;
	localparam logic [15:0] MAX_BENCH_S = 16'h003C;
	localparam logic [1:0] SEVT_RST_MASK = 2'h3;
	localparam logic [1:0] SEVT_ONCHANGE = 2'h1;
	localparam logic [1:0] SEVT_ALWAYS = 2'h3;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SVC_5HZ_MS = 8'hC8;
	localparam logic [7:0] SVC_10HZ_MS = 8'h64;
	localparam logic [9:0] SEC_MS = 10'h3E8;
	// ----------------------------------------
	// automatic output table defaults
	// ----------------------------------------
	localparam int N_ENT = 16;
	localparam logic [15:0] DEF_USED = 16'h03FF;
	localparam logic [15:0] DEF_CODE [16] = '{16'h1201, 16'h3002,
		16'h3101, 16'h3201, 16'h3301, 16'h3603, 16'h3604, 16'h3605,
		16'h3607, 16'h3608, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};
	localparam logic [31:0] EV_POS = 32'h0000_0C00;
	localparam logic [31:0] DEF_EVT [16] = '{32'h0020_0000,
		32'h0000_0000, EV_POS, EV_POS, EV_POS, 32'h0400_0000,
		32'h0400_0000, 32'h0200_0000, 32'h0100_0000, 32'h0400_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000};
	localparam int DEF_TTRG_ENT = 1;
	localparam logic [31:0] DEF_TTRG = 32'h0000_00C8;
	// ----------------------------------------
	// host register map (apb byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_DATA0 = 8'h04;
	localparam logic [7:0] A_DATA1 = 8'h08;
	localparam logic [7:0] A_CTRL = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_RSP0 = 8'h14;
	localparam logic [7:0] A_RSP1 = 8'h18;
	localparam logic [7:0] A_RPTC = 8'h1C;
	localparam logic [7:0] A_RPTD = 8'h20;
	localparam logic [7:0] A_RPTN = 8'h24;
	typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} rtc_hst_e;
endpackage

/* File: logic/rtc_if.sv */
`timescale 1ns/1ps
interface rtc_if;
	logic cmd_valid;
	logic cmd_ready;
	logic [7:0] cmd_code;
	logic [7:0] cmd_sub;
	logic [7:0] cmd_index;
	logic cmd_query;
	logic [31:0] cmd_data0;
	logic [31:0] cmd_data1;
	logic rsp_valid;
	logic [1:0] rsp_ack;
	logic [31:0] rsp_data0;
	logic [31:0] rsp_data1;
	logic rpt_valid;
	logic [15:0] rpt_code;
	logic [31:0] rpt_data;
	modport dev(input cmd_valid, cmd_code, cmd_sub, cmd_index, cmd_query,
		cmd_data0, cmd_data1, output cmd_ready, rsp_valid, rsp_ack,
		rsp_data0, rsp_data1, rpt_valid, rpt_code, rpt_data);
	modport host(output cmd_valid, cmd_code, cmd_sub, cmd_index, cmd_query,
		cmd_data0, cmd_data1, input cmd_ready, rsp_valid, rsp_ack,
		rsp_data0, rsp_data1, rpt_valid, rpt_code, rpt_data);
endinterface

/* File: logic/rtc_dev.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module rtc_dev #(
	parameter int CYC_PER_MS = rtc_pkg::CYC_PER_MS,
	parameter int N_ENT = rtc_pkg::N_ENT
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	rtc_if.dev lnk,
	input wire logic [31:0] dist_i,
	input wire logic [31:0] hdg_i,
	input wire logic [31:0] event_i,
	input wire logic sevt_valid_i,
	input wire logic [6:0] sevt_id_i,
	input wire logic sevt_val_i,
	output logic rate_10hz_o,
	output logic sys_rst_o,
	output logic tick_o,
	output logic [2:0] test_run_o,
	output logic sevt_rpt_o,
	output logic [6:0] sevt_rpt_id_o
);
	localparam int IW = $clog2(N_ENT);
	localparam int MW = $clog2(CYC_PER_MS);
	if (CYC_PER_MS < 2 || N_ENT < 10 || N_ENT > 16) begin : g_chk
		$error("rtc_dev: unsupported parameter values");
	end
	// ----------------------------------------
	// time base
	// ----------------------------------------
	logic [MW-1:0] ms_cnt;
	logic ms_en;
	logic [7:0] svc_ms;
	logic [31:0] now_ms;
	logic [7:0] svc_per;
	assign svc_per = rate_10hz_o ? rtc_pkg::SVC_10HZ_MS : rtc_pkg::SVC_5HZ_MS;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ms_cnt <= '0;
			ms_en <= 1'b0;
		end else begin
			ms_en <= (ms_cnt == MW'(CYC_PER_MS - 1));
			ms_cnt <= (ms_cnt == MW'(CYC_PER_MS - 1)) ? '0 : ms_cnt + 1'b1;
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			svc_ms <= '0;
			now_ms <= '0;
			tick_o <= 1'b0;
		end else if (sys_rst_o) begin
			svc_ms <= '0;
			now_ms <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= ms_en && (svc_ms == svc_per - 8'h01);
			if (ms_en) begin
				now_ms <= now_ms + 32'h0000_0001;
				svc_ms <= (svc_ms == svc_per - 8'h01) ? '0 : svc_ms + 8'h01;
			end
		end
	end
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic [15:0] ent_code [N_ENT];
	logic [N_ENT-1:0] ent_used;
	logic [31:0] ev_msk [N_ENT];
	logic [31:0] thr [N_ENT][3];
	logic [31:0] trg [N_ENT][3];
	logic [31:0] ref_v [N_ENT][3];
	logic [1:0] sev_msk [128];
	logic [127:0] sev_last;
	logic [15:0] t_left [3];
	logic [9:0] t_ms [3];
	logic [31:0] t_stat [3];
	logic [2:0] t_done;
	logic take;
	logic [N_ENT-1:0] match;
	logic [IW-1:0] hit_idx, free_idx;
	logic hit, free_ok, tbl_we, sev_we, rate_we, t_we;
	logic [1:0] ack, k, tsel;
	logic [31:0] q0, q1;
	logic [15:0] ival, tmax;
	assign take = lnk.cmd_valid && lnk.cmd_ready;
	assign k = 2'(lnk.cmd_code - rtc_pkg::CMD_TIME);
	assign ival = lnk.cmd_data0[15:0];
	always_comb begin
		match = '0;
		hit = 1'b0;
		hit_idx = '0;
		free_ok = 1'b0;
		free_idx = '0;
		for (int i = N_ENT - 1; i >= 0; i--) begin
			match[i] = ent_used[i] && ent_code[i][15:8] == lnk.cmd_sub &&
				(lnk.cmd_index == rtc_pkg::SUB_ALL ||
				ent_code[i][7:0] == lnk.cmd_index);
			if (match[i]) begin
				hit = 1'b1;
				hit_idx = IW'(i);
			end
			if (!ent_used[i]) begin
				free_ok = 1'b1;
				free_idx = IW'(i);
			end
		end
	end
	always_comb begin
		ack = rtc_pkg::ACK_OK;
		q0 = '0;
		q1 = '0;
		tbl_we = 1'b0;
		sev_we = 1'b0;
		rate_we = 1'b0;
		t_we = 1'b0;
		tsel = 2'h0;
		tmax = rtc_pkg::MAX_BENCH_S;
		case (lnk.cmd_code)
			rtc_pkg::CMD_EVT, rtc_pkg::CMD_TIME, rtc_pkg::CMD_DIST,
			rtc_pkg::CMD_HDG: begin
				if (lnk.cmd_query) begin
					if (!hit) begin
						ack = rtc_pkg::ACK_ERR;
					end else if (lnk.cmd_code == rtc_pkg::CMD_EVT) begin
						q0 = ev_msk[hit_idx];
					end else begin
						q0 = thr[hit_idx][k];
						q1 = trg[hit_idx][k];
					end
				end else if (!hit && (lnk.cmd_index == rtc_pkg::SUB_ALL ||
						!free_ok)) begin
					ack = rtc_pkg::ACK_ERR;
				end else begin
					tbl_we = 1'b1;
				end
			end
			rtc_pkg::CMD_SEVT: begin
				if (lnk.cmd_sub != rtc_pkg::SUB_ONE || (lnk.cmd_index[7] &&
						lnk.cmd_index != rtc_pkg::SUB_ALL)) begin
					ack = rtc_pkg::ACK_ERR;
				end else if (lnk.cmd_query) begin
					if (lnk.cmd_index[7]) begin
						ack = rtc_pkg::ACK_ERR;
					end else begin
						q0 = {30'h0000_0000, sev_msk[lnk.cmd_index[6:0]]};
					end
				end else begin
					sev_we = 1'b1;
				end
			end
			rtc_pkg::CMD_TEST: begin
				case (lnk.cmd_sub)
					rtc_pkg::SUB_COLL: tmax = rtc_pkg::MAX_COLL_S;
					rtc_pkg::SUB_GYRO: tsel = 2'h1;
					rtc_pkg::SUB_TACHO: tsel = 2'h2;
					default: ack = rtc_pkg::ACK_ERR;
				endcase
				if (lnk.cmd_query) begin
					ack = rtc_pkg::ACK_ERR;
				end else if (ival > tmax) begin
					ack = rtc_pkg::ACK_ERR;
				end else if (ack == rtc_pkg::ACK_OK && ival != 16'h0000 &&
						test_run_o[tsel]) begin
					ack = rtc_pkg::ACK_CONTRA;
				end
				t_we = (ack == rtc_pkg::ACK_OK);
			end
			rtc_pkg::CMD_RATE: begin
				if (lnk.cmd_sub != rtc_pkg::SUB_ONE) begin
					ack = rtc_pkg::ACK_ERR;
				end else if (lnk.cmd_query) begin
					q0 = {24'h00_0000, rate_10hz_o ? rtc_pkg::RATE_10HZ :
						rtc_pkg::RATE_5HZ};
				end else if (lnk.cmd_data0[7:0] == rtc_pkg::RATE_5HZ ||
						lnk.cmd_data0[7:0] == rtc_pkg::RATE_10HZ) begin
					rate_we = 1'b1;
				end else begin
					ack = rtc_pkg::ACK_ERR;
				end
			end
			default: ack = rtc_pkg::ACK_ERR;
		endcase
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lnk.cmd_ready <= 1'b1;
			lnk.rsp_valid <= 1'b0;
			lnk.rsp_ack <= rtc_pkg::ACK_OK;
			lnk.rsp_data0 <= '0;
			lnk.rsp_data1 <= '0;
		end else begin
			lnk.cmd_ready <= !take;
			lnk.rsp_valid <= take;
			if (take) begin
				lnk.rsp_ack <= ack;
				lnk.rsp_data0 <= q0;
				lnk.rsp_data1 <= q1;
			end
		end
	end
	// ----------------------------------------
	// engine rate and forced reset
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rate_10hz_o <= rtc_pkg::RATE_RST_10HZ;
			sys_rst_o <= 1'b0;
		end else begin
			sys_rst_o <= 1'b0;
			if (take && rate_we) begin
				rate_10hz_o <= (lnk.cmd_data0[7:0] == rtc_pkg::RATE_10HZ);
				sys_rst_o <= (lnk.cmd_data0[7:0] == rtc_pkg::RATE_10HZ) !=
					rate_10hz_o;
			end
		end
	end
	// ----------------------------------------
	// output table contents
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i || sys_rst_o) begin
			for (int i = 0; i < N_ENT; i++) begin
				ent_used[i] <= rtc_pkg::DEF_USED[i];
				ent_code[i] <= rtc_pkg::DEF_CODE[i];
				ev_msk[i] <= rtc_pkg::DEF_EVT[i];
				for (int c = 0; c < 3; c++) begin
					thr[i][c] <= '0;
					trg[i][c] <= (i == rtc_pkg::DEF_TTRG_ENT && c == 0) ?
						rtc_pkg::DEF_TTRG : '0;
				end
			end
		end else if (take && tbl_we) begin
			for (int i = 0; i < N_ENT; i++) begin
				if (match[i] || (!hit && free_idx == IW'(i))) begin
					ent_used[i] <= 1'b1;
					if (!hit) begin
						ent_code[i] <= {lnk.cmd_sub, lnk.cmd_index};
					end
					if (lnk.cmd_code == rtc_pkg::CMD_EVT) begin
						ev_msk[i] <= lnk.cmd_data0;
					end else begin
						thr[i][k] <= lnk.cmd_data0;
						trg[i][k] <= lnk.cmd_data1;
					end
				end
			end
		end
	end
	// ----------------------------------------
	// table scan on service tick
	// ----------------------------------------
	logic scan;
	logic [IW-1:0] sidx;
	logic [31:0] evt_acc, evt_snap, hd;
	logic [31:0] dd [3];
	logic [2:0] pend, pfirst;
	logic pass, need, fire;
	assign pfirst = pend & (~pend + 3'h1);
	always_comb begin
		dd[0] = now_ms - ref_v[sidx][0];
		dd[1] = dist_i - ref_v[sidx][1];
		hd = hdg_i - ref_v[sidx][2];
		dd[2] = hd[31] ? 32'h0000_0000 - hd : hd;
		pass = 1'b1;
		need = (evt_snap & ev_msk[sidx]) != '0;
		for (int c = 0; c < 3; c++) begin
			pass = pass && (thr[sidx][c] == '0 || dd[c] > thr[sidx][c]);
			need = need || (trg[sidx][c] != '0 && dd[c] > trg[sidx][c]);
		end
		fire = scan && ent_used[sidx] && pass && need;
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scan <= 1'b0;
			sidx <= '0;
			evt_acc <= '0;
			evt_snap <= '0;
			pend <= '0;
			lnk.rpt_valid <= 1'b0;
			lnk.rpt_code <= '0;
			lnk.rpt_data <= '0;
			for (int i = 0; i < N_ENT; i++) begin
				for (int c = 0; c < 3; c++) begin
					ref_v[i][c] <= '0;
				end
			end
		end else if (sys_rst_o) begin
			scan <= 1'b0;
			sidx <= '0;
			evt_acc <= '0;
			pend <= '0;
			lnk.rpt_valid <= 1'b0;
			for (int i = 0; i < N_ENT; i++) begin
				ref_v[i][0] <= '0;
				ref_v[i][1] <= dist_i;
				ref_v[i][2] <= hdg_i;
			end
		end else begin
			lnk.rpt_valid <= 1'b0;
			evt_acc <= tick_o ? event_i : (evt_acc | event_i);
			pend <= pend | t_done;
			if (tick_o) begin
				scan <= 1'b1;
				sidx <= '0;
				evt_snap <= evt_acc;
			end else if (scan) begin
				scan <= (sidx != IW'(N_ENT - 1));
				sidx <= sidx + 1'b1;
			end
			if (fire) begin
				lnk.rpt_valid <= 1'b1;
				lnk.rpt_code <= ent_code[sidx];
				lnk.rpt_data <= now_ms;
				ref_v[sidx][0] <= now_ms;
				ref_v[sidx][1] <= dist_i;
				ref_v[sidx][2] <= hdg_i;
			end else begin
				for (int t = 2; t >= 0; t--) begin
					if (pend[t]) begin
						lnk.rpt_valid <= 1'b1;
						lnk.rpt_code <= {rtc_pkg::RPT_TEST, 5'h00,
							2'(t + 1), 1'b0};
						lnk.rpt_data <= t_stat[t];
					end
				end
				pend <= (pend & ~pfirst) | t_done;
			end
		end
	end
	// ----------------------------------------
	// timed tests
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i || sys_rst_o) begin
			test_run_o <= '0;
			t_done <= '0;
			for (int t = 0; t < 3; t++) begin
				t_left[t] <= '0;
				t_stat[t] <= '0;
				t_ms[t] <= '0;
			end
		end else begin
			t_done <= '0;
			for (int t = 0; t < 3; t++) begin
				if (take && t_we && tsel == 2'(t)) begin
					if (ival == 16'h0000) begin
						test_run_o[t] <= 1'b0;
						t_done[t] <= test_run_o[t];
					end else begin
						test_run_o[t] <= 1'b1;
						t_left[t] <= ival;
						t_stat[t] <= '0;
						t_ms[t] <= '0;
					end
				end else if (test_run_o[t]) begin
					if (tick_o) begin
						t_stat[t] <= t_stat[t] + 32'h0000_0001;
					end
					if (ms_en) begin
						t_ms[t] <= t_ms[t] + 10'h001;
					end
					if (ms_en && t_ms[t] == rtc_pkg::SEC_MS - 10'h001) begin
						t_ms[t] <= '0;
						t_left[t] <= t_left[t] - 16'h0001;
						if (t_left[t] == 16'h0001) begin
							test_run_o[t] <= 1'b0;
							t_done[t] <= 1'b1;
						end
					end
				end
			end
		end
	end
	// ----------------------------------------
	// soft event masks
	// ----------------------------------------
	logic [1:0] sm;
	assign sm = sev_msk[sevt_id_i];
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i || sys_rst_o) begin
			for (int e = 0; e < 128; e++) begin
				sev_msk[e] <= rtc_pkg::SEVT_RST_MASK;
			end
			sev_last <= '0;
			sevt_rpt_o <= 1'b0;
			sevt_rpt_id_o <= '0;
		end else begin
			sevt_rpt_o <= 1'b0;
			if (take && sev_we) begin
				for (int e = 0; e < 128; e++) begin
					if (lnk.cmd_index == rtc_pkg::SUB_ALL ||
							lnk.cmd_index[6:0] == 7'(e)) begin
						sev_msk[e] <= lnk.cmd_data0[1:0];
					end
				end
			end
			if (sevt_valid_i) begin
				sev_last[sevt_id_i] <= sevt_val_i;
				sevt_rpt_o <= sm == rtc_pkg::SEVT_ALWAYS ||
					(sm == rtc_pkg::SEVT_ONCHANGE &&
					sev_last[sevt_id_i] != sevt_val_i);
				sevt_rpt_id_o <= sevt_id_i;
			end
		end
	end
endmodule // rtc_dev

/* File: logic/rtc_host.sv */
`timescale 1ns/1ps
module rtc_host (
	input wire logic mclk_i,
	input wire logic nrst_i,
	rtc_if.host lnk,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	rtc_pkg::rtc_hst_e st;
	logic [24:0] cmd_r;
	logic [31:0] d0, d1, r0, r1, rptd, rptn;
	logic [15:0] rptc;
	logic [1:0] ack_r;
	logic done_r, go, wr;
	logic [31:0] rd;
	logic hit;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign go = wr && paddr == rtc_pkg::A_CTRL && pwdata[0];
	always_comb begin
		hit = 1'b1;
		case (paddr)
			rtc_pkg::A_CMD: rd = {7'h00, cmd_r};
			rtc_pkg::A_DATA0: rd = d0;
			rtc_pkg::A_DATA1: rd = d1;
			rtc_pkg::A_CTRL: rd = '0;
			rtc_pkg::A_STAT: rd = {28'h000_0000, done_r, ack_r,
				st != rtc_pkg::H_IDLE};
			rtc_pkg::A_RSP0: rd = r0;
			rtc_pkg::A_RSP1: rd = r1;
			rtc_pkg::A_RPTC: rd = {16'h0000, rptc};
			rtc_pkg::A_RPTD: rd = rptd;
			rtc_pkg::A_RPTN: rd = rptn;
			default: begin
				rd = '0;
				hit = 1'b0;
			end
		endcase
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && !hit;
			if (psel && !penable && !pready) begin
				prdata <= pwrite ? '0 : rd;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_r <= '0;
			d0 <= '0;
			d1 <= '0;
		end else if (wr && st == rtc_pkg::H_IDLE) begin
			if (paddr == rtc_pkg::A_CMD) cmd_r <= pwdata[24:0];
			if (paddr == rtc_pkg::A_DATA0) d0 <= pwdata;
			if (paddr == rtc_pkg::A_DATA1) d1 <= pwdata;
		end
	end
	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= rtc_pkg::H_IDLE;
			lnk.cmd_valid <= 1'b0;
			lnk.cmd_code <= '0;
			lnk.cmd_sub <= '0;
			lnk.cmd_index <= '0;
			lnk.cmd_query <= 1'b0;
			lnk.cmd_data0 <= '0;
			lnk.cmd_data1 <= '0;
			ack_r <= '0;
			done_r <= 1'b0;
			r0 <= '0;
			r1 <= '0;
		end else begin
			case (st)
				rtc_pkg::H_IDLE: if (go) begin
					st <= rtc_pkg::H_SEND;
					done_r <= 1'b0;
					lnk.cmd_valid <= 1'b1;
					lnk.cmd_code <= cmd_r[7:0];
					lnk.cmd_sub <= cmd_r[15:8];
					lnk.cmd_index <= cmd_r[23:16];
					lnk.cmd_query <= cmd_r[24];
					lnk.cmd_data0 <= d0;
					lnk.cmd_data1 <= d1;
				end
				rtc_pkg::H_SEND: if (lnk.cmd_ready) begin
					st <= rtc_pkg::H_WAIT;
					lnk.cmd_valid <= 1'b0;
				end
				rtc_pkg::H_WAIT: if (lnk.rsp_valid) begin
					st <= rtc_pkg::H_IDLE;
					ack_r <= lnk.rsp_ack;
					r0 <= lnk.rsp_data0;
					r1 <= lnk.rsp_data1;
					done_r <= 1'b1;
				end
				default: st <= rtc_pkg::H_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// unsolicited reports
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rptc <= '0;
			rptd <= '0;
			rptn <= '0;
		end else if (lnk.rpt_valid) begin
			rptc <= lnk.rpt_code;
			rptd <= lnk.rpt_data;
			rptn <= rptn + 32'h0000_0001;
		end
	end
endmodule // rtc_host

/* File: sim/rtc_props.sv */
`timescale 1ns/1ps
module rtc_props (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_sub,
	input wire logic cmd_query,
	input wire logic [31:0] cmd_data0,
	input wire logic rsp_valid,
	input wire logic [1:0] rsp_ack,
	input wire logic rpt_valid,
	input wire logic [15:0] rpt_code
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	logic tk, tst, tsub, rt, rok;
	logic [15:0] mx;
	assign tk = cmd_valid && cmd_ready;
	assign tst = tk && cmd_code == rtc_pkg::CMD_TEST;
	assign tsub = cmd_sub inside {8'h02, 8'h04, 8'h06};
	assign mx = (cmd_sub == rtc_pkg::SUB_COLL) ? 16'h0E10 : 16'h003C;
	assign rt = tk && cmd_code == rtc_pkg::CMD_RATE && !cmd_query &&
		cmd_sub == rtc_pkg::SUB_ONE;
	assign rok = cmd_data0[7:0] inside {8'h05, 8'h0A};
	// ----------------------------------------
	// link handshake
	// ----------------------------------------
	a_rsp_after_take: assert property (tk |=> rsp_valid ##1 !rsp_valid)
		else $error("answer not one cycle after take");
	a_rsp_has_cause: assert property (rsp_valid |-> $past(tk))
		else $error("answer without a take");
	a_ready_low_one: assert property (tk |=> !cmd_ready ##1 cmd_ready)
		else $error("ready not low for exactly one cycle");
	// ----------------------------------------
	// test and rate commands
	// ----------------------------------------
	a_test_over_max: assert property (tst && tsub && !cmd_query &&
		cmd_data0[15:0] > mx |=> rsp_ack == rtc_pkg::ACK_ERR)
		else $error("over-range interval not refused");
	a_test_no_query: assert property (tst && cmd_query
		|=> rsp_ack == rtc_pkg::ACK_ERR)
		else $error("test interval query not refused");
	a_test_in_range: assert property (tst && tsub && !cmd_query &&
		cmd_data0[15:0] <= mx |=> rsp_ack != rtc_pkg::ACK_ERR)
		else $error("legal interval refused");
	a_rate_bad_val: assert property (rt && !rok
		|=> rsp_ack == rtc_pkg::ACK_ERR)
		else $error("bad rate accepted");
	a_rate_good_val: assert property (rt && rok
		|=> rsp_ack == rtc_pkg::ACK_OK)
		else $error("good rate refused");
	a_test_rpt_code: assert property (rpt_valid && rpt_code[15:8] == 8'h3F
		|-> rpt_code[7:0] inside {8'h02, 8'h04, 8'h06})
		else $error("bad test report code");
	c_test_refused: cover property (tst && !cmd_query && cmd_data0[15:0] > mx);
	c_rate_set: cover property (rt && rok);
	c_test_report: cover property (rpt_valid && rpt_code[15:8] == 8'h3F);
endmodule // rtc_props

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, r0, r1, hdg_i = 0;
	logic [31:0] dist_i = 0, event_i = 0;
	logic pready, pslverr, serr, sevt_valid_i = 0, sevt_val_i = 0;
	logic [6:0] sevt_id_i = 0, sevt_rpt_id_o;
	logic rate_10hz_o, sys_rst_o, tick_o, sevt_rpt_o;
	logic [2:0] test_run_o;
	logic [1:0] ack;
	int err_count = 0, comparisons = 0, cyc = 0, last = 0, gap = 0;
	int since = 0, nsr = 0, nsev = 0, n31 = 0, t0, n;
	int nt [4] = '{0, 0, 0, 0};
	always #50 mclk_i = ~mclk_i;
	rtc_if lnk();
	rtc_dev #(.CYC_PER_MS(10)) u_rtc_dev(.mclk_i(mclk_i), .nrst_i(nrst_i),
		.lnk(lnk), .dist_i(dist_i), .hdg_i(hdg_i), .event_i(event_i),
		.sevt_valid_i(sevt_valid_i), .sevt_id_i(sevt_id_i),
		.sevt_val_i(sevt_val_i), .rate_10hz_o(rate_10hz_o),
		.sys_rst_o(sys_rst_o), .tick_o(tick_o), .test_run_o(test_run_o),
		.sevt_rpt_o(sevt_rpt_o), .sevt_rpt_id_o(sevt_rpt_id_o));
	rtc_host u_rtc_host(.mclk_i(mclk_i), .nrst_i(nrst_i), .lnk(lnk),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	rtc_props u_rtc_props(.mclk_i(mclk_i), .nrst_i(nrst_i),
		.cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready),
		.cmd_code(lnk.cmd_code), .cmd_sub(lnk.cmd_sub),
		.cmd_query(lnk.cmd_query), .cmd_data0(lnk.cmd_data0),
		.rsp_valid(lnk.rsp_valid), .rsp_ack(lnk.rsp_ack),
		.rpt_valid(lnk.rpt_valid), .rpt_code(lnk.rpt_code));
	// ----------------------------------------
	// monitors and shared tasks
	// ----------------------------------------
	task chk(input logic c, input string m);
		comparisons++;
		if (c !== 1'b1) begin
			err_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task results;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task tmo(input int lim);
		if (n >= lim) begin
			chk(1'b0, "wait timed out");
			results();
		end
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		since = tick_o ? 0 : since + 1;
		if (tick_o) begin
			gap = cyc - last;
			last = cyc;
		end
		if (sys_rst_o) nsr++;
		if (sevt_rpt_o) nsev++;
		if (lnk.rpt_valid) begin
			if (lnk.rpt_code === 16'h3101) n31++;
			if (lnk.rpt_code[15:8] === 8'h3F) nt[lnk.rpt_code[2:1]]++;
			else chk(since <= 17, "report off tick");
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		serr = pslverr;
		tmo(20);
		psel <= 0;
		penable <= 0;
		@(posedge mclk_i);
	endtask
	task cmd(input logic [7:0] c, s, i, input logic q, input logic [31:0] d);
		apb(1, rtc_pkg::A_DATA0, d);
		apb(1, rtc_pkg::A_DATA1, d);
		apb(1, rtc_pkg::A_CMD, {7'h00, q, i, s, c});
		apb(1, rtc_pkg::A_CTRL, 32'h0000_0001);
		for (int k = 0; k < 30; k++) begin
			apb(0, rtc_pkg::A_STAT, 32'h0000_0000);
			if (rd[0] === 1'b0 && rd[3] === 1'b1) break;
		end
		if (rd[3] !== 1'b1) begin
			chk(1'b0, "no answer");
			results();
		end
		ack = rd[2:1];
		apb(0, rtc_pkg::A_RSP0, 32'h0000_0000);
		r0 = rd;
		apb(0, rtc_pkg::A_RSP1, 32'h0000_0000);
		r1 = rd;
	endtask
	task sev(input logic [6:0] id, input int e);
		int b;
		b = nsev;
		sevt_valid_i <= 1;
		sevt_id_i <= id;
		sevt_val_i <= 1;
		@(posedge mclk_i);
		sevt_valid_i <= 0;
		repeat (1100) @(posedge mclk_i);
		chk(nsev - b == e && (e == 0 || sevt_rpt_id_o === id), "soft rpt");
	endtask
	task wait_end(input int t);
		n = 0;
		while (test_run_o[t] !== 1'b0 && n < 12000) begin
			@(posedge mclk_i);
			n++;
		end
		tmo(12000);
		repeat (40) @(posedge mclk_i);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge mclk_i);
		nrst_i <= 1;
		@(posedge mclk_i);
		chk(rate_10hz_o === 1'b1 && test_run_o === 3'h0, "reset outs");
		apb(0, 8'h40, 32'h0000_0000);
		chk(serr === 1'b1 && rd === 32'h0000_0000, "unmapped read");
		cmd(rtc_pkg::CMD_TIME, 8'h30, 8'h02, 1, 0);
		chk(ack === 2'h0 && r1 === 32'h0000_00C8, "fast fix trig");
		cmd(rtc_pkg::CMD_EVT, 8'h33, 8'h01, 1, 0);
		chk(r0 === 32'h0000_0C00, "position events");
		cmd(rtc_pkg::CMD_EVT, 8'h36, 8'h07, 1, 0);
		chk(r0 === 32'h0100_0000, "calibration event");
		cmd(rtc_pkg::CMD_HDG, 8'h12, 8'h01, 1, 0);
		chk(r0 === 32'h0000_0000 && r1 === 32'h0000_0000, "hdg dflt");
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'h05, 1, 0);
		chk(r0[1:0] === 2'h3, "mask reset");
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'hFF, 0, 32'h0000_0001);
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'h7F, 1, 0);
		chk(r0[1:0] === 2'h1, "mask all");
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'h06, 0, 32'h0000_0000);
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'h07, 0, 32'h0000_0003);
		sev(7'h05, 1);
		sev(7'h05, 0);
		sev(7'h06, 0);
		sev(7'h07, 1);
		sev(7'h07, 1);
		chk(gap == 1000, "tick 10 Hz");
		cmd(rtc_pkg::CMD_TEST, 8'h02, 8'h00, 0, 32'h0000_0001);
		t0 = cyc;
		chk(ack === 2'h0 && test_run_o[0] === 1'b1, "coll start");
		cmd(rtc_pkg::CMD_TEST, 8'h02, 8'h00, 0, 32'h0000_0005);
		chk(ack === 2'h1, "coll running");
		cmd(rtc_pkg::CMD_TEST, 8'h02, 8'h00, 1, 0);
		chk(ack === 2'h2, "test query");
		cmd(rtc_pkg::CMD_TEST, 8'h04, 8'h00, 0, 32'h0000_003D);
		chk(ack === 2'h2 && test_run_o[1] === 1'b0, "gyro 61");
		cmd(rtc_pkg::CMD_HDG, 8'h31, 8'h01, 0, 32'h0000_01F4);
		hdg_i <= 32'h0000_01F4;
		repeat (2100) @(posedge mclk_i);
		chk(n31 == 0, "hdg at trigger");
		hdg_i <= 32'h0000_01F5;
		repeat (1100) @(posedge mclk_i);
		chk(n31 == 1 && test_run_o[0] === 1'b1, "hdg past trig");
		repeat (2100) @(posedge mclk_i);
		chk(n31 == 1, "hdg reference kept");
		wait_end(0);
		chk(cyc - t0 > 9970 && cyc - t0 < 10080, "coll length");
		chk(nt[1] == 1, "coll report");
		cmd(rtc_pkg::CMD_TEST, 8'h02, 8'h00, 0, 32'h0000_0E11);
		chk(ack === 2'h2 && test_run_o === 3'h0, "coll 3601");
		cmd(rtc_pkg::CMD_TEST, 8'h04, 8'h00, 0, 32'h0000_003C);
		chk(ack === 2'h0 && test_run_o[1] === 1'b1, "gyro 60");
		cmd(rtc_pkg::CMD_TEST, 8'h04, 8'h00, 0, 32'h0000_0000);
		wait_end(1);
		chk(nt[2] == 1, "gyro stop report");
		cmd(rtc_pkg::CMD_TEST, 8'h06, 8'h00, 0, 32'h0000_0001);
		chk(test_run_o[2] === 1'b1, "tacho run");
		wait_end(2);
		chk(nt[3] == 1, "tacho report");
		for (int j = 0; j < 7; j++) begin
			cmd(rtc_pkg::CMD_DIST, 8'h50, 8'(j), 0, 0);
		end
		chk(ack === 2'h2, "table full");
		cmd(rtc_pkg::CMD_RATE, 8'h01, 8'h00, 0, 32'h0000_0007);
		chk(ack === 2'h2 && nsr == 0, "rate 7");
		cmd(rtc_pkg::CMD_RATE, 8'h01, 8'h00, 0, 32'h0000_0005);
		chk(nsr == 1 && rate_10hz_o === 1'b0, "rate 5");
		repeat (4500) @(posedge mclk_i);
		chk(gap == 2000, "tick 5 Hz");
		cmd(rtc_pkg::CMD_SEVT, 8'h01, 8'h05, 1, 0);
		chk(r0[1:0] === 2'h3, "mask after reset");
		cmd(rtc_pkg::CMD_RATE, 8'h01, 8'h00, 0, 32'h0000_000A);
		chk(nsr == 2 && rate_10hz_o === 1'b1, "rate 10");
		results();
	end
endmodule // testbench
